// [sense_pkg.sv]
// Shared constants and carrier types for the tape sense data collector.
package sense_pkg;
   // ****************************************************************
   // Sizes and limits
   // ****************************************************************
   localparam int INIT_COUNT = 8;
   localparam int ID_W = 3;
   localparam logic [23:0] DATA_ERR_MAX = 24'h0F_FFFF;
   localparam logic [23:0] DATA_ERR_ONE = 24'h00_0001;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [7:0] RESPONSE_CODE = 8'h70;
   localparam logic [7:0] ADD_SENSE_LEN = 8'h15;
   localparam int VALID_BIT = 7;
   // ****************************************************************
   // Sense byte indexes
   // ****************************************************************
   localparam logic [4:0] IDX_CODE = 5'h00;
   localparam logic [4:0] IDX_KEY = 5'h02;
   localparam logic [4:0] IDX_INFO0 = 5'h03;
   localparam logic [4:0] IDX_INFO1 = 5'h04;
   localparam logic [4:0] IDX_INFO2 = 5'h05;
   localparam logic [4:0] IDX_INFO3 = 5'h06;
   localparam logic [4:0] IDX_LEN = 5'h07;
   localparam logic [4:0] IDX_ASC = 5'h0C;
   localparam logic [4:0] IDX_ASCQ = 5'h0D;
   localparam logic [4:0] IDX_DERR0 = 5'h10;
   localparam logic [4:0] IDX_DERR1 = 5'h11;
   localparam logic [4:0] IDX_DERR2 = 5'h12;
   localparam logic [4:0] IDX_UNIT0 = 5'h13;
   localparam logic [4:0] IDX_UNIT1 = 5'h14;
   localparam logic [4:0] IDX_UNIT2 = 5'h15;
   localparam logic [4:0] IDX_REM0 = 5'h17;
   localparam logic [4:0] IDX_REM1 = 5'h18;
   localparam logic [4:0] IDX_REM2 = 5'h19;
   localparam logic [4:0] IDX_TRACK = 5'h1A;
   localparam logic [4:0] IDX_RETRY = 5'h1B;
   localparam logic [4:0] IDX_FSC = 5'h1C;
   // The last of the 29 sense bytes; reading it completes a full record.
   localparam logic [4:0] IDX_LAST = 5'h1C;
   // ****************************************************************
   // Sense keys
   // ****************************************************************
   localparam logic [3:0] KEY_NONE = 4'h0;
   localparam logic [3:0] KEY_NOT_READY = 4'h2;
   localparam logic [3:0] KEY_MEDIUM = 4'h3;
   localparam logic [3:0] KEY_HARDWARE = 4'h4;
   localparam logic [3:0] KEY_ILLEGAL = 4'h5;
   localparam logic [3:0] KEY_POSITION = 4'h9;
   localparam logic [3:0] KEY_ABORTED = 4'hB;
   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef enum logic [1:0] {CMD_REQUEST_SENSE, CMD_INQUIRY, CMD_OTHER} command_kind_t;
   typedef struct packed {
      logic rewrite;
      logic ecc_fix;
      logic track_retry;
      logic rw_retry;
      logic tape_load;
      logic rewind;
      logic bus_parity_fault;
      logic buffer_parity_fault;
      logic tape_flaw_fault;
      logic tracking_fault;
      logic filemark_space_fault;
      logic filemark_write_fault;
      logic formatter_underrun;
      logic rewrite_limit_hit;
      logic servo_fault;
      logic formatter_fault;
      logic reverse_retry;
      logic cleaning_done;
      logic cleaning_due;
      logic splice_blank_fault;
      logic splice_overshoot_fault;
      logic mode_select_bad;
   } drive_event_t;
   typedef struct packed {
      logic write_mode;
      logic no_cartridge;
      logic logical_tape_start;
      logic write_protect;
      logic physical_tape_end;
      logic [23:0] logical_tape_end_mark;
      logic [23:0] position;
   } drive_status_t;
   typedef struct packed {
      logic pending;
      logic clear_armed;
      logic reset_seen_flag;
      logic bus_parity_fault;
      logic buffer_parity_fault;
      logic tape_flaw_fault;
      logic retry_count_wrap_flag;
      logic tracking_fault;
      logic filemark_space_fault;
      logic filemark_write_fault;
      logic formatter_underrun;
      logic rewrite_limit_hit;
      logic servo_fault;
      logic formatter_fault;
      logic reverse_retry_flag;
      logic cleaning_done;
      logic cleaning_due;
      logic splice_blank_fault;
      logic splice_overshoot_fault;
      logic illegal_param;
      logic valid;
      logic [31:0] info;
      logic [7:0] asc;
      logic [7:0] ascq;
      logic [7:0] fault_code;
   } sense_store_t;
endpackage

// [tape_sense_data_collector.sv]
// Sense data collector: counters, unit sense flags and per-initiator pending sense.
`timescale 1ns/1ps
// How it works
// - Write mode: rewrite after read-after-write failure bumps data error counter.
// - Read mode: block rebuilt by error correction bumps data error counter.
// - Data error counter saturates at its maximum, never wraps.
// - Request sense with clear bit clears counters when the last of the 29 bytes is read.
// - Load, rewind, read/write mode change and reset clear all counters.
// - Tracking error at motion start-up bumps the tracking retry counter.
// - Failed read or write with retry bumps the read/write retry counter.
// - Read/write retry counter wrapping to zero sets the wrap flag.
// - Unit sense flags read one only when their condition holds; reserved read zero.
// - Byte 19 reports reset, bus parity, buffer parity, media, tracking, no cartridge.
// - Tape start, write protect and tape end follow live conditions.
// - Failed filemark space sets flag, valid bit and remaining filemark count.
// - Formatter underrun also sets the formatter fault flag.
// - Byte 20 reports filemark write, rewrite limit, servo and formatter faults.
// - Reverse retry flag sets on motion retries, clears only on new tape.
// - Cleaning done flag clears at the next request sense.
// - Cleaning due flag clears only after a successful cleaning.
// - Byte 21 reports splice blank tape and splice overshoot faults.
// - Remaining tape is signed end mark minus position, zero without cartridge.
// - Bad mode select gives illegal request and one-based byte index.
// - Sense key follows the most severe stored error while sense is pending; otherwise it reads no sense.
// - Pending sense kept until initiator's next other command or any reset.
// - Information bytes meaningful only while the valid bit is one.
// - Additional sense length always reads 21.
module tape_sense_data_collector
   import sense_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic bus_reset,
   input wire drive_event_t drive_event,
   input wire logic [ID_W-1:0] event_initiator,
   input wire logic check_condition,
   input wire logic [7:0] check_asc,
   input wire logic [7:0] check_ascq,
   input wire logic [31:0] filemark_requested,
   input wire logic [31:0] filemark_processed,
   input wire logic [7:0] mode_select_bad_index,
   input wire drive_status_t drive_status,
   input wire logic cmd_valid,
   input wire command_kind_t cmd_kind,
   input wire logic [ID_W-1:0] cmd_initiator,
   input wire logic counter_clear_request,
   input wire logic sense_read,
   input wire logic [ID_W-1:0] sense_initiator,
   input wire logic [4:0] sense_index,
   output logic [7:0] sense_data,
   output logic sense_data_valid,
   output logic [INIT_COUNT-1:0] sense_pending
);
   // ****************************************************************
   // Shared drive counters
   // ****************************************************************
   logic [23:0] data_error_count;
   logic [7:0] tracking_retry_count;
   logic [7:0] rw_retry_count;
   logic prev_write_mode;
   logic [23:0] next_data_error_count;
   logic [7:0] next_tracking_retry_count;
   logic [7:0] next_rw_retry_count;
   logic next_prev_write_mode;
   logic counter_clear;
   logic host_clear;
   logic retry_wrap;
   sense_store_t store [INIT_COUNT];
   sense_store_t next_store [INIT_COUNT];

   // The host clear only fires when the final byte is read for an initiator armed by its request sense.
   assign host_clear = sense_read && (sense_index == IDX_LAST) &&
                       store[sense_initiator].clear_armed;
   assign counter_clear = host_clear || drive_event.tape_load || drive_event.rewind ||
                          (prev_write_mode != drive_status.write_mode) || bus_reset;
   assign retry_wrap = drive_event.rw_retry && (rw_retry_count == BYTE_MAX) && !counter_clear;

   // Counter next values; every clear is checked first so it beats an increment.
   always_comb begin
      next_data_error_count = data_error_count;
      next_tracking_retry_count = tracking_retry_count;
      next_rw_retry_count = rw_retry_count;
      next_prev_write_mode = drive_status.write_mode;
      if (counter_clear) begin
         next_data_error_count = '0;
         next_tracking_retry_count = '0;
         next_rw_retry_count = '0;
      end else begin
         if (((drive_status.write_mode && drive_event.rewrite) ||
              (!drive_status.write_mode && drive_event.ecc_fix)) &&
             (data_error_count != DATA_ERR_MAX)) begin
            next_data_error_count = data_error_count + DATA_ERR_ONE;
         end
         if (drive_event.track_retry) begin
            next_tracking_retry_count = tracking_retry_count + BYTE_ONE;
         end
         if (drive_event.rw_retry) begin
            next_rw_retry_count = rw_retry_count + BYTE_ONE;
         end
      end
   end

   // Counters register; a device reset clears them too.
   always_ff @(posedge clock) begin
      if (rst) begin
         data_error_count <= '0;
         tracking_retry_count <= '0;
         rw_retry_count <= '0;
         prev_write_mode <= 1'b0;
      end else begin
         data_error_count <= next_data_error_count;
         tracking_retry_count <= next_tracking_retry_count;
         rw_retry_count <= next_rw_retry_count;
         prev_write_mode <= next_prev_write_mode;
      end
   end

   // ****************************************************************
   // Per-initiator sense storage
   // ****************************************************************
   // Severity order of the stored errors, most catastrophic first.
   function automatic logic [3:0] key_of(input sense_store_t s);
      logic [3:0] k;
      k = KEY_NONE;
      if (s.bus_parity_fault) begin
         k = KEY_ABORTED;
      end else if (s.servo_fault || s.formatter_fault || s.buffer_parity_fault ||
                   s.splice_blank_fault || s.splice_overshoot_fault) begin
         k = KEY_HARDWARE;
      end else if (s.illegal_param) begin
         k = KEY_ILLEGAL;
      end else if (s.tape_flaw_fault || s.rewrite_limit_hit || s.filemark_write_fault) begin
         k = KEY_MEDIUM;
      end else if (s.filemark_space_fault || s.tracking_fault) begin
         k = KEY_POSITION;
      end else if (drive_status.no_cartridge) begin
         k = KEY_NOT_READY;
      end
      return k;
   endfunction

   // Each slot sees only events aimed at its own initiator, apart from the
   // drive-wide conditions that every initiator must be told about.
   always_comb begin
      for (int i = 0; i < INIT_COUNT; i++) begin
         next_store[i] = store[i];
         if (drive_event.tape_load) begin
            next_store[i].reverse_retry_flag = 1'b0;
         end
         if (drive_event.reverse_retry) begin
            next_store[i].reverse_retry_flag = 1'b1;
         end
         if (drive_event.cleaning_done) begin
            next_store[i].cleaning_due = 1'b0;
         end
         if (drive_event.cleaning_due) begin
            next_store[i].cleaning_due = 1'b1;
         end
         // Discard of stored sense by a new command comes before fresh events so a set wins.
         if (cmd_valid && (cmd_initiator == ID_W'(i))) begin
            if (cmd_kind == CMD_REQUEST_SENSE) begin
               next_store[i].clear_armed = counter_clear_request;
               next_store[i].cleaning_done = 1'b0;
            end else if (cmd_kind == CMD_OTHER) begin
               next_store[i].pending = 1'b0;
               next_store[i].clear_armed = 1'b0;
               next_store[i].reset_seen_flag = 1'b0;
               next_store[i].bus_parity_fault = 1'b0;
               next_store[i].buffer_parity_fault = 1'b0;
               next_store[i].tape_flaw_fault = 1'b0;
               next_store[i].retry_count_wrap_flag = 1'b0;
               next_store[i].tracking_fault = 1'b0;
               next_store[i].filemark_space_fault = 1'b0;
               next_store[i].filemark_write_fault = 1'b0;
               next_store[i].formatter_underrun = 1'b0;
               next_store[i].rewrite_limit_hit = 1'b0;
               next_store[i].servo_fault = 1'b0;
               next_store[i].formatter_fault = 1'b0;
               next_store[i].splice_blank_fault = 1'b0;
               next_store[i].splice_overshoot_fault = 1'b0;
               next_store[i].illegal_param = 1'b0;
               next_store[i].valid = 1'b0;
               next_store[i].info = '0;
               next_store[i].fault_code = '0;
            end
         end
         if (host_clear && (sense_initiator == ID_W'(i))) begin
            next_store[i].clear_armed = 1'b0;
         end
         if (drive_event.cleaning_done) begin
            next_store[i].cleaning_done = 1'b1;
         end
         if (retry_wrap) begin
            next_store[i].retry_count_wrap_flag = 1'b1;
         end
         if (event_initiator == ID_W'(i)) begin
            if (drive_event.bus_parity_fault) next_store[i].bus_parity_fault = 1'b1;
            if (drive_event.buffer_parity_fault) next_store[i].buffer_parity_fault = 1'b1;
            if (drive_event.tape_flaw_fault) next_store[i].tape_flaw_fault = 1'b1;
            if (drive_event.tracking_fault) next_store[i].tracking_fault = 1'b1;
            if (drive_event.filemark_write_fault) next_store[i].filemark_write_fault = 1'b1;
            if (drive_event.rewrite_limit_hit) next_store[i].rewrite_limit_hit = 1'b1;
            if (drive_event.servo_fault) next_store[i].servo_fault = 1'b1;
            if (drive_event.formatter_fault || drive_event.formatter_underrun) begin
               next_store[i].formatter_fault = 1'b1;
            end
            if (drive_event.formatter_underrun) next_store[i].formatter_underrun = 1'b1;
            if (drive_event.splice_blank_fault) next_store[i].splice_blank_fault = 1'b1;
            if (drive_event.splice_overshoot_fault) next_store[i].splice_overshoot_fault = 1'b1;
            if (drive_event.filemark_space_fault) begin
               next_store[i].filemark_space_fault = 1'b1;
               next_store[i].valid = 1'b1;
               next_store[i].info = filemark_requested - filemark_processed;
            end
            if (drive_event.mode_select_bad) begin
               next_store[i].illegal_param = 1'b1;
               next_store[i].fault_code = mode_select_bad_index + BYTE_ONE;
            end
            if (check_condition) begin
               next_store[i].pending = 1'b1;
               next_store[i].asc = check_asc;
               next_store[i].ascq = check_ascq;
            end
         end
         // A bus reset drops every pending record and marks the reset for all.
         if (bus_reset) begin
            next_store[i] = '0;
            next_store[i].reset_seen_flag = 1'b1;
            next_store[i].cleaning_due = store[i].cleaning_due;
            next_store[i].reverse_retry_flag = store[i].reverse_retry_flag;
         end
      end
   end

   // Storage register; power-on leaves every initiator with only the reset flag.
   always_ff @(posedge clock) begin
      for (int i = 0; i < INIT_COUNT; i++) begin
         if (rst) begin
            store[i] <= '0;
            store[i].reset_seen_flag <= 1'b1;
         end else begin
            store[i] <= next_store[i];
         end
      end
   end

   // ****************************************************************
   // Sense byte read-out
   // ****************************************************************
   sense_store_t sel;
   logic [23:0] remaining;
   logic [7:0] next_sense_data;
   logic [INIT_COUNT-1:0] next_sense_pending;

   assign sel = store[sense_initiator];
   // Wraps naturally to a two's complement negative once past the end mark.
   assign remaining = drive_status.no_cartridge ? '0 :
                      drive_status.logical_tape_end_mark - drive_status.position;

   // Byte multiplexer; unlisted and reserved positions read zero.
   always_comb begin
      next_sense_data = '0;
      for (int i = 0; i < INIT_COUNT; i++) begin
         next_sense_pending[i] = next_store[i].pending;
      end
      case (sense_index)
         IDX_CODE: next_sense_data = RESPONSE_CODE | {sel.valid, 7'h00};
         IDX_KEY: next_sense_data = {4'h0, sel.pending ? key_of(sel) : KEY_NONE};
         IDX_INFO0: next_sense_data = sel.valid ? sel.info[31:24] : '0;
         IDX_INFO1: next_sense_data = sel.valid ? sel.info[23:16] : '0;
         IDX_INFO2: next_sense_data = sel.valid ? sel.info[15:8] : '0;
         IDX_INFO3: next_sense_data = sel.valid ? sel.info[7:0] : '0;
         IDX_LEN: next_sense_data = ADD_SENSE_LEN;
         IDX_ASC: next_sense_data = sel.asc;
         IDX_ASCQ: next_sense_data = sel.ascq;
         IDX_DERR0: next_sense_data = data_error_count[23:16];
         IDX_DERR1: next_sense_data = data_error_count[15:8];
         IDX_DERR2: next_sense_data = data_error_count[7:0];
         IDX_UNIT0: next_sense_data = {sel.reset_seen_flag, sel.bus_parity_fault,
                                       sel.buffer_parity_fault, sel.tape_flaw_fault,
                                       sel.retry_count_wrap_flag, sel.tracking_fault,
                                       drive_status.no_cartridge,
                                       drive_status.logical_tape_start};
         IDX_UNIT1: next_sense_data = {1'b0, sel.filemark_space_fault,
                                       drive_status.write_protect, sel.filemark_write_fault,
                                       sel.formatter_underrun, sel.rewrite_limit_hit,
                                       sel.servo_fault, sel.formatter_fault};
         IDX_UNIT2: next_sense_data = {2'b00, sel.reverse_retry_flag, sel.cleaning_done,
                                       sel.cleaning_due, drive_status.physical_tape_end,
                                       sel.splice_blank_fault, sel.splice_overshoot_fault};
         IDX_REM0: next_sense_data = remaining[23:16];
         IDX_REM1: next_sense_data = remaining[15:8];
         IDX_REM2: next_sense_data = remaining[7:0];
         IDX_TRACK: next_sense_data = tracking_retry_count;
         IDX_RETRY: next_sense_data = rw_retry_count;
         IDX_FSC: next_sense_data = sel.fault_code;
         default: next_sense_data = '0;
      endcase
   end

   // Output register: one byte answers each read request a cycle later.
   always_ff @(posedge clock) begin
      if (rst) begin
         sense_data <= '0;
         sense_data_valid <= 1'b0;
         sense_pending <= '0;
      end else begin
         sense_data <= sense_read ? next_sense_data : '0;
         sense_data_valid <= sense_read;
         sense_pending <= next_sense_pending;
      end
   end
endmodule

// [tape_sense_props.sv]
// Port-level assertion checker for the tape sense data collector.
`timescale 1ns/1ps
module tape_sense_props
   import sense_pkg::*;
(
   input wire logic clock, rst, bus_reset, check_condition, cmd_valid, sense_read,
   input wire logic [ID_W-1:0] event_initiator, cmd_initiator,
   input wire drive_status_t drive_status,
   input wire command_kind_t cmd_kind,
   input wire logic [4:0] sense_index,
   input wire logic [7:0] sense_data,
   input wire logic [INIT_COUNT-1:0] sense_pending
);
   // One clock domain; a reset abandons every check in flight.
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_len; sense_read && sense_index == IDX_LEN |=> sense_data == ADD_SENSE_LEN; endproperty
   a_len: assert property (p_len) else $error("bad length byte");
   property p_resv; sense_read && sense_index inside {5'h0E, 5'h16} |=> sense_data == 8'h00; endproperty
   a_resv: assert property (p_resv) else $error("reserved byte not zero");
   property p_wp; sense_read && sense_index == IDX_UNIT1
      |=> {sense_data[7], sense_data[5]} == {1'b0, $past(drive_status.write_protect)}; endproperty
   a_wp: assert property (p_wp) else $error("write protect flag wrong");
   property p_rem; sense_read && drive_status.no_cartridge && sense_index == IDX_REM2
      |=> sense_data == 8'h00; endproperty
   a_rem: assert property (p_rem) else $error("remaining tape not zero");
   property p_pend; check_condition && !bus_reset |=> sense_pending[$past(event_initiator)]; endproperty
   a_pend: assert property (p_pend) else $error("sense not pending");
   property p_disc; cmd_valid && cmd_kind == CMD_OTHER && !check_condition
      |=> !sense_pending[$past(cmd_initiator)]; endproperty
   a_disc: assert property (p_disc) else $error("sense not discarded");
   property p_keep; cmd_valid && cmd_kind == CMD_OTHER && cmd_initiator != 3'h0 && sense_pending[0] && !bus_reset
      |=> sense_pending[0]; endproperty
   a_keep: assert property (p_keep) else $error("other initiator lost sense");
   property p_rst; $fell(rst) |-> sense_pending == '0; endproperty
   a_rst: assert property (p_rst) else $error("pending after reset");
   property p_sat; sense_read && sense_index == IDX_DERR0 |=> sense_data[7:4] == 4'h0; endproperty
   a_sat: assert property (p_sat) else $error("data error count above its maximum");
   c_check: cover property (check_condition);
   c_record: cover property (sense_read && sense_index == IDX_LAST);
   c_discard: cover property (cmd_valid && cmd_kind == CMD_OTHER);
endmodule
bind tape_sense_data_collector tape_sense_props u_props (.clock, .rst, .bus_reset, .check_condition, .cmd_valid,
   .sense_read, .event_initiator, .cmd_initiator, .drive_status, .cmd_kind, .sense_index, .sense_data, .sense_pending);

// [sense_host_model.sv]
// Host initiator model that fetches single sense bytes.
`timescale 1ns/1ps
module sense_host_model
   import sense_pkg::*;
(
   input wire logic clock, sense_data_valid,
   input wire logic [7:0] sense_data,
   output logic sense_read = 1'b0,
   output logic [ID_W-1:0] sense_initiator = '0,
   output logic [4:0] sense_index = '0
);
   // The index is inverted once released so a stale value never passes for a live one.
   task automatic read_byte(input logic [ID_W-1:0] id, input logic [4:0] x, output logic [7:0] v);
      {sense_read, sense_initiator, sense_index} <= {1'b1, id, x};
      @(posedge clock);
      {sense_read, sense_index} <= {1'b0, ~x};
      @(posedge clock);
      v = (sense_data_valid === 1'b1) ? sense_data : 8'hxx;
   endtask
endmodule

// [tape_sense_data_collector_tb_top.sv]
// Self-checking bench for the tape sense data collector.
`timescale 1ns/1ps
module tape_sense_data_collector_tb_top
   import sense_pkg::*;
;
   logic clock = 1'b0, rst = 1'b1, bus_reset = 1'b0, check_condition = 1'b0, cmd_valid = 1'b0;
   logic counter_clear_request = 1'b0, sense_read, sense_data_valid;
   logic [ID_W-1:0] event_initiator = '0, cmd_initiator = '0, sense_initiator;
   logic [7:0] mode_select_bad_index = 8'h00, check_ascq = 8'h00, sense_data, b;
   logic [31:0] filemark_requested = 32'h0000_0000, filemark_processed = 32'h0000_0000;
   logic [4:0] sense_index;
   logic [INIT_COUNT-1:0] sense_pending;
   command_kind_t cmd_kind = CMD_INQUIRY;
   drive_event_t drive_event = '0;
   drive_status_t drive_status = '0;
   int miscompares = 0, comparisons = 0;
   // Clock at 200 MHz.
   always #2.5 clock = ~clock;
   // The additional sense code stays at zero here.
   tape_sense_data_collector u_dut (.clock, .rst, .bus_reset, .drive_event, .event_initiator, .check_condition,
      .check_asc(8'h00), .check_ascq, .filemark_requested, .filemark_processed,
      .mode_select_bad_index, .drive_status, .cmd_valid, .cmd_kind, .cmd_initiator, .counter_clear_request,
      .sense_read, .sense_initiator, .sense_index, .sense_data, .sense_data_valid, .sense_pending);
   sense_host_model u_host (.clock, .sense_data_valid, .sense_data, .sense_read, .sense_initiator, .sense_index);
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) $display("unexpected at %0t got %h expected %h", $time, g, e);
      if (g !== e) miscompares++;
   endtask
   task automatic rd(input logic [2:0] id, input logic [4:0] x, input logic [7:0] m, input logic [7:0] e);
      u_host.read_byte(id, x, b);
      ck(b & m, e);
   endtask
   task automatic pl(input drive_event_t e, input logic [2:0] id, input logic cc);
      {drive_event, event_initiator, check_condition} <= {e, id, cc};
      @(posedge clock);
      {drive_event, check_condition} <= '0;
      @(posedge clock);
   endtask
   task automatic cm(input logic [2:0] id, input command_kind_t k, input logic clr);
      cmd_kind <= k;
      {cmd_valid, cmd_initiator, counter_clear_request} <= {1'b1, id, clr};
      @(posedge clock);
      cmd_valid <= 1'b0;
      @(posedge clock);
   endtask
   // Per-mode counting, a clear that beats an event, a retry wrap and a host clear.
   task automatic t_count();
      drive_status.write_mode <= 1'b1;
      @(posedge clock);
      repeat (3) pl('{rewrite: 1'b1, track_retry: 1'b1, default: 1'b0}, 3'h0, 1'b0);
      pl('{ecc_fix: 1'b1, rw_retry: 1'b1, default: 1'b0}, 3'h0, 1'b0);
      rd(3'h0, IDX_DERR2, 8'hFF, 8'h03);
      rd(3'h0, IDX_TRACK, 8'hFF, 8'h03);
      rd(3'h0, IDX_RETRY, 8'hFF, 8'h01);
      drive_status.write_mode <= 1'b0;
      pl('{ecc_fix: 1'b1, default: 1'b0}, 3'h0, 1'b0);
      rd(3'h0, IDX_DERR2, 8'hFF, 8'h00);
      repeat (256) pl('{rw_retry: 1'b1, default: 1'b0}, 3'h0, 1'b0);
      rd(3'h5, IDX_UNIT0, 8'h08, 8'h08);
      pl('{ecc_fix: 1'b1, default: 1'b0}, 3'h0, 1'b0);
      cm(3'h2, CMD_REQUEST_SENSE, 1'b1);
      rd(3'h2, IDX_DERR2, 8'hFF, 8'h01);
      for (int i = 0; i < 29; i++) u_host.read_byte(3'h2, 5'(i), b);
      rd(3'h2, IDX_DERR2, 8'hFF, 8'h00);
   endtask
   // Key priority, per-initiator keeping, discard, bus reset and tape position.
   task automatic t_sense();
      pl('{bus_parity_fault: 1'b1, tape_flaw_fault: 1'b1, default: 1'b0}, 3'h0, 1'b1);
      ck(sense_pending, 8'h01);
      rd(3'h0, IDX_KEY, 8'h0F, {4'h0, KEY_ABORTED});
      rd(3'h0, IDX_UNIT0, 8'h50, 8'h50);
      pl('{formatter_underrun: 1'b1, default: 1'b0}, 3'h4, 1'b0);
      rd(3'h4, IDX_UNIT1, 8'h89, 8'h09);
      cm(3'h0, CMD_INQUIRY, 1'b0);
      cm(3'h0, CMD_REQUEST_SENSE, 1'b0);
      cm(3'h3, CMD_OTHER, 1'b0);
      ck(sense_pending, 8'h01);
      cm(3'h0, CMD_OTHER, 1'b0);
      mode_select_bad_index <= 8'h03;
      pl('{mode_select_bad: 1'b1, default: 1'b0}, 3'h6, 1'b1);
      rd(3'h6, IDX_FSC, 8'hFF, 8'h04);
      rd(3'h6, IDX_KEY, 8'h0F, {4'h0, KEY_ILLEGAL});
      bus_reset <= 1'b1;
      @(posedge clock);
      bus_reset <= 1'b0;
      rd(3'h0, IDX_UNIT0, 8'h80, 8'h80);
      ck(sense_pending, 8'h00);
      {drive_status.logical_tape_end_mark, drive_status.position} <= {24'h00_0064, 24'h00_006E};
      rd(3'h1, IDX_REM0, 8'hFF, 8'hFF);
      drive_status.no_cartridge <= 1'b1;
      rd(3'h1, IDX_REM2, 8'hFF, 8'h00);
   endtask
   // Filemark count, live bits, codes and the maintenance flags.
   task automatic t_flags();
      {filemark_requested, filemark_processed, check_ascq} <= {32'h0000_0009, 32'h0000_0002, 8'h5A};
      {drive_status.write_protect, drive_status.physical_tape_end} <= 2'b11;
      pl('{filemark_space_fault: 1'b1, default: 1'b0}, 3'h1, 1'b1);
      rd(3'h1, IDX_INFO3, 8'hFF, 8'h07);
      rd(3'h1, IDX_UNIT1, 8'hE0, 8'h60);
      rd(3'h1, IDX_KEY, 8'h0F, {4'h0, KEY_POSITION});
      rd(3'h1, IDX_ASCQ, 8'hFF, 8'h5A);
      pl('{reverse_retry: 1'b1, cleaning_due: 1'b1, splice_overshoot_fault: 1'b1, default: 1'b0}, 3'h1, 1'b0);
      rd(3'h1, IDX_UNIT2, 8'hFF, 8'h2D);
      pl('{cleaning_done: 1'b1, default: 1'b0}, 3'h1, 1'b0);
      rd(3'h1, IDX_UNIT2, 8'h18, 8'h10);
      cm(3'h1, CMD_REQUEST_SENSE, 1'b0);
      rd(3'h1, IDX_UNIT2, 8'h10, 8'h00);
   endtask
   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Main sequence after 20 cycles of reset.
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_count();
      t_sense();
      t_flags();
      final_report();
   end
   // Watchdog, several times the expected run length.
   initial begin
      #20000;
      miscompares++;
      final_report();
   end
endmodule
